// ---- logic/sram_pkg.sv ----
package sram_pkg;

  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;
  localparam int PAGE_W = 5;
  localparam int PAGE_COUNT = 8192;
  localparam int ADDR_BYTES = 3;
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;

  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_ENTER_DUAL = 8'h3B;
  localparam logic [7:0] OP_ENTER_QUAD = 8'h38;
  localparam logic [7:0] OP_EXIT_MULTI = 8'hFF;
  localparam logic [7:0] OP_READ_MODE = 8'h05;
  localparam logic [7:0] OP_WRITE_MODE = 8'h01;

  localparam logic [1:0] MODE_BYTE = 2'h0;
  localparam logic [1:0] MODE_PAGE = 2'h2;
  localparam logic [1:0] MODE_SEQ = 2'h1;
  localparam logic [1:0] MODE_RESET = MODE_SEQ;

  localparam logic [3:0] STEP_SINGLE = 4'h1;
  localparam logic [3:0] STEP_DUAL = 4'h2;
  localparam logic [3:0] STEP_QUAD = 4'h4;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef enum logic [1:0] {
    IO_SINGLE = 2'h0,
    IO_DUAL = 2'h1,
    IO_QUAD = 2'h3
  } io_mode_t;

  typedef enum logic [2:0] {
    ST_CMD = 3'h0,
    ST_ADDR = 3'h1,
    ST_WDATA = 3'h3,
    ST_RDATA = 3'h5,
    ST_MREAD = 3'h4,
    ST_MWRITE = 3'h2,
    ST_DONE = 3'h7
  } state_t;

endpackage

// ---- logic/pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  if (WIDTH < 1)
  begin : g_chk
    $error("pin_sync WIDTH must be at least 1");
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule

// ---- logic/byte_store.sv ----
`timescale 1ns/1ps
module byte_store #(
  parameter int ADDR_W = 18,
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data
);
  logic [DATA_W-1:0] mem_reg [2**ADDR_W];

  if (ADDR_W < 1 || DATA_W < 1)
  begin : g_chk
    $error("byte_store widths must be at least 1");
  end

  // Array contents are undefined after power-up, as in the real part
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem_reg[rd_addr];
endmodule

// ---- logic/serial_sram.sv ----
// Summary of operation
// R1 - Select high: standby, output lanes floated
// R2 - Master selects once after power-up
// R3 - Sample on rising, update after falling
// R4 - All bytes move most significant first
// R5 - First eight bits form the instruction
// R6 - Master holds select low whole command
// R7 - Read is 03h, write is 02h
// R8 - 24-bit address, top six bits ignored
// R9 - Mode bits 7:6 choose addressing
// R10 - Byte mode: exactly one data byte
// R11 - Page mode wraps within 32 bytes
// R12 - Sequential mode rolls 3FFFFh to 00000h
// R13 - Read advances address after each byte
// R14 - Raising select ends the transfer
// R15 - Pause suspends without losing the sequence
// R16 - Pause starts with clock low
// R17 - While paused, clock and input ignored
// R18 - Resume starts with clock low
// R19 - Pause floats output at once
// R20 - No pause in quad mode
// R21 - Dual mode uses lanes 0 and 1
// R22 - Quad mode uses all four lanes
// R23 - 3Bh enters dual, 38h enters quad
// R24 - FFh returns to single-bit mode
// R25 - 05h reads, 01h writes mode register
// R26 - Sequential is default, 11 reserved
// R27 - Unknown instruction: idle until deselect
`timescale 1ns/1ps
module serial_sram
  import sram_pkg::*;
#(
  parameter int MEM_ADDR_W = ADDR_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic select_n,
  input wire logic sck,
  input wire logic io_lane_0_in,
  output logic io_lane_0_out,
  output logic io_lane_0_oe_n,
  input wire logic io_lane_1_in,
  output logic io_lane_1_out,
  output logic io_lane_1_oe_n,
  input wire logic io_lane_2_in,
  output logic io_lane_2_out,
  output logic io_lane_2_oe_n,
  input wire logic io_lane_3_in,
  output logic io_lane_3_out,
  output logic io_lane_3_oe_n,
  output logic [1:0] mode_bits,
  output logic dual_io_mode,
  output logic quad_io_mode,
  output logic paused
);
  if (MEM_ADDR_W != ADDR_W)
  begin : g_chk
    $error("serial_sram supports only an 18-bit array address");
  end

  logic [5:0] pin_raw;
  logic [5:0] pin_s;
  logic sel_s;
  logic sck_s;
  logic [3:0] lane_s;
  logic pause_s;

  assign pin_raw = {select_n, sck, io_lane_3_in, io_lane_2_in,
                    io_lane_1_in, io_lane_0_in};

  // Select and pause reset to their idle high level: no false selection
  pin_sync #(.WIDTH(6), .RST_VAL(6'h28)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(pin_raw),
    .sync_out(pin_s)
  );

  assign sel_s = pin_s[5];
  assign sck_s = pin_s[4];
  assign lane_s = pin_s[3:0];
  assign pause_s = pin_s[3];

  state_t state_reg, state_next;
  io_mode_t io_reg, io_next;
  logic [1:0] mode_reg, mode_next;
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic [1:0] addr_cnt_reg, addr_cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] instr_reg, instr_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [7:0] out_sh_reg, out_sh_next;
  logic [3:0] out_data_reg, out_data_next;
  logic drive_reg, drive_next;
  logic one_done_reg, one_done_next;
  logic paused_reg, paused_next;
  logic sck_d_reg;

  logic rise;
  logic fall;
  logic pause_ok;
  logic [3:0] step;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic [3:0] lanes_out;
  logic byte_in_end;
  logic byte_out_end;
  logic [ADDR_W-1:0] addr_adv;
  logic [ADDR_W+5:0] addr_full;
  logic wr_en;
  logic [7:0] rd_data;
  logic drive_act;

  byte_store #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_store (
    .clk(clk),
    .wr_en(wr_en),
    .wr_addr(addr_reg),
    .wr_data(shift_in),
    .rd_addr(addr_next),
    .rd_data(rd_data)
  );

  // Pause pin is a data lane in quad mode
  assign pause_ok = (io_reg == IO_QUAD) || pause_s; // R20
  // Edges are only seen while selected and not paused
  assign rise = sck_s && !sck_d_reg && !paused_reg && pause_ok && !sel_s; // R3 R17
  assign fall = !sck_s && sck_d_reg && !paused_reg && pause_ok && !sel_s; // R3 R17

  always_comb
  begin
    step = STEP_SINGLE;
    shift_in = {sh_reg[6:0], lane_s[0]};
    shift_out = {out_sh_reg[6:0], 1'b0};
    lanes_out = {2'h0, out_sh_reg[7], 1'b0};
    case (io_reg)
      IO_DUAL:
      begin
        step = STEP_DUAL; // R21
        shift_in = {sh_reg[5:0], lane_s[1], lane_s[0]};
        shift_out = {out_sh_reg[5:0], 2'h0};
        lanes_out = {2'h0, out_sh_reg[7:6]};
      end
      IO_QUAD:
      begin
        step = STEP_QUAD; // R22
        shift_in = {sh_reg[3:0], lane_s};
        shift_out = {out_sh_reg[3:0], 4'h0};
        lanes_out = out_sh_reg[7:4];
      end
      default:
      begin
        step = STEP_SINGLE;
      end
    endcase
  end

  assign byte_in_end = rise && (({1'b0, bit_cnt_reg} + step) == BYTE_BITS);
  assign byte_out_end = fall && (({1'b0, bit_cnt_reg} + step) == BYTE_BITS);
  assign addr_full = {addr_reg[ADDR_W-3:0], shift_in}; // R8

  always_comb
  begin
    if (mode_reg == MODE_PAGE)
    begin
      addr_adv = {addr_reg[ADDR_W-1:PAGE_W],
                  addr_reg[PAGE_W-1:0] + 5'h1}; // R11
    end
    else
    begin
      addr_adv = addr_reg + 18'h1; // R12
    end
  end

  always_comb
  begin
    state_next = state_reg;
    io_next = io_reg;
    mode_next = mode_reg;
    bit_cnt_next = bit_cnt_reg;
    addr_cnt_next = addr_cnt_reg;
    sh_next = sh_reg;
    instr_next = instr_reg;
    addr_next = addr_reg;
    out_sh_next = out_sh_reg;
    out_data_next = out_data_reg;
    drive_next = drive_reg;
    one_done_next = one_done_reg;
    paused_next = paused_reg;
    wr_en = 1'b0;
    if (sel_s)
    begin
      state_next = ST_CMD; // R1 R14
      bit_cnt_next = 3'h0;
      drive_next = 1'b0;
      paused_next = 1'b0;
    end
    else
    begin
      if (io_reg == IO_QUAD)
      begin
        paused_next = 1'b0; // R20
      end
      else if (!sck_s)
      begin
        paused_next = !pause_s; // R15 R16 R18
      end
      // Read states count bits on falling edges only
      if (rise && state_reg != ST_RDATA && state_reg != ST_MREAD)
      begin
        sh_next = shift_in; // R4
        bit_cnt_next = 3'(bit_cnt_reg + step[2:0]);
      end
      case (state_reg)
        ST_CMD:
        begin
          if (byte_in_end)
          begin
            instr_next = shift_in; // R5
            addr_cnt_next = 2'h0;
            one_done_next = 1'b0;
            case (shift_in)
              OP_READ, OP_WRITE: state_next = ST_ADDR; // R7
              OP_READ_MODE:
              begin
                state_next = ST_MREAD; // R25
                out_sh_next = {mode_reg, 6'h00};
              end
              OP_WRITE_MODE: state_next = ST_MWRITE; // R25
              OP_ENTER_DUAL:
              begin
                io_next = IO_DUAL; // R23
                state_next = ST_DONE;
              end
              OP_ENTER_QUAD:
              begin
                io_next = IO_QUAD; // R23
                state_next = ST_DONE;
              end
              OP_EXIT_MULTI:
              begin
                io_next = IO_SINGLE; // R24
                state_next = ST_DONE;
              end
              default: state_next = ST_DONE; // R27
            endcase
          end
        end
        ST_ADDR:
        begin
          if (byte_in_end)
          begin
            addr_next = addr_full[ADDR_W-1:0]; // R8
            addr_cnt_next = 2'(addr_cnt_reg + 2'h1);
            if (addr_cnt_reg == 2'(ADDR_BYTES - 1))
            begin
              if (instr_reg == OP_READ)
              begin
                state_next = ST_RDATA;
                out_sh_next = rd_data;
              end
              else
              begin
                state_next = ST_WDATA;
              end
            end
          end
        end
        ST_WDATA:
        begin
          if (byte_in_end)
          begin
            wr_en = 1'b1;
            addr_next = addr_adv;
            if (mode_reg == MODE_BYTE)
            begin
              state_next = ST_DONE; // R10
            end
          end
        end
        ST_RDATA, ST_MREAD:
        begin
          if (fall)
          begin
            if (one_done_reg)
            begin
              state_next = ST_DONE; // R10
              drive_next = 1'b0;
            end
            else
            begin
              drive_next = 1'b1;
              out_data_next = lanes_out; // R3 R4
              out_sh_next = shift_out;
              bit_cnt_next = 3'(bit_cnt_reg + step[2:0]);
              if (byte_out_end && state_reg == ST_RDATA)
              begin
                addr_next = addr_adv; // R13
                out_sh_next = rd_data;
                one_done_next = (mode_reg == MODE_BYTE);
              end
              else if (byte_out_end)
              begin
                out_sh_next = {mode_reg, 6'h00};
              end
            end
          end
        end
        ST_MWRITE:
        begin
          if (byte_in_end)
          begin
            mode_next = shift_in[MODE_HI:MODE_LO]; // R9 R25
            state_next = ST_DONE;
          end
        end
        default:
        begin
          state_next = ST_DONE; // R27
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_CMD;
      io_reg <= IO_SINGLE;
      mode_reg <= MODE_RESET; // R26
      bit_cnt_reg <= 3'h0;
      addr_cnt_reg <= 2'h0;
      sh_reg <= 8'h00;
      instr_reg <= 8'h00;
      addr_reg <= '0;
      out_sh_reg <= 8'h00;
      out_data_reg <= 4'h0;
      drive_reg <= 1'b0;
      one_done_reg <= 1'b0;
      paused_reg <= 1'b0;
      sck_d_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      io_reg <= io_next;
      mode_reg <= mode_next;
      bit_cnt_reg <= bit_cnt_next;
      addr_cnt_reg <= addr_cnt_next;
      sh_reg <= sh_next;
      instr_reg <= instr_next;
      addr_reg <= addr_next;
      out_sh_reg <= out_sh_next;
      out_data_reg <= out_data_next;
      drive_reg <= drive_next;
      one_done_reg <= one_done_next;
      paused_reg <= paused_next;
      sck_d_reg <= sck_s;
    end
  end

  // Floating follows the pause pin level directly, not the paused state
  assign drive_act = drive_reg && !sel_s && pause_ok; // R1 R19
  assign io_lane_1_out = out_data_reg[1];
  assign io_lane_1_oe_n = !drive_act;
  assign io_lane_0_out = out_data_reg[0];
  assign io_lane_0_oe_n = !(drive_act && io_reg != IO_SINGLE); // R21
  assign io_lane_3_out = out_data_reg[3];
  assign io_lane_3_oe_n = !(drive_act && io_reg == IO_QUAD); // R22
  assign io_lane_2_out = out_data_reg[2];
  assign io_lane_2_oe_n = !(drive_act && io_reg == IO_QUAD); // R22
  assign mode_bits = mode_reg;
  assign dual_io_mode = (io_reg == IO_DUAL);
  assign quad_io_mode = (io_reg == IO_QUAD);
  assign paused = paused_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence cmd_byte_s;
    state_reg == ST_CMD && byte_in_end;
  endsequence

  desel_float_a: assert property (sel_s |-> io_lane_1_oe_n && io_lane_0_oe_n
    && io_lane_2_oe_n && io_lane_3_oe_n) // R1
    else $error("output driven while deselected");
  cmd_leave_a: assert property (cmd_byte_s |=> state_reg != ST_CMD) // R5
    else $error("instruction byte not taken");
  read_op_a: assert property (cmd_byte_s ##0 shift_in == OP_READ
    |=> state_reg == ST_ADDR && instr_reg == OP_READ) // R7
    else $error("read opcode not decoded");
  byte_stop_a: assert property (wr_en && mode_reg == MODE_BYTE
    |=> state_reg == ST_DONE) // R10
    else $error("byte mode accepted a second byte");
  page_wrap_a: assert property (wr_en && mode_reg == MODE_PAGE
    |=> addr_reg[ADDR_W-1:PAGE_W] == $past(addr_reg[ADDR_W-1:PAGE_W])) // R11
    else $error("page mode left its page");
  seq_roll_a: assert property (wr_en && mode_reg == MODE_SEQ
    && addr_reg == 18'h3FFFF |=> addr_reg == 18'h00000) // R12
    else $error("sequential roll over failed");
  pause_freeze_a: assert property (paused_reg && !sel_s
    |=> state_reg == $past(state_reg) && bit_cnt_reg == $past(bit_cnt_reg)) // R17
    else $error("sequence moved while paused");
  pause_float_a: assert property (!pause_s && io_reg != IO_QUAD
    |-> io_lane_1_oe_n && io_lane_0_oe_n) // R19
    else $error("output driven with pause low");
  quad_nopause_a: assert property (io_reg == IO_QUAD ##1 io_reg == IO_QUAD
    |-> !paused_reg) // R20
    else $error("pause active in quad mode");
  fall_update_a: assert property ($changed(out_data_reg) |-> $past(fall)) // R3
    else $error("output data changed off a falling edge");
  done_quiet_a: assert property (state_reg == ST_DONE |-> !drive_reg
    ##1 (state_reg == ST_DONE || state_reg == ST_CMD)) // R27
    else $error("idle state drove or left early");
  mode_write_a: assert property (state_reg == ST_MWRITE && byte_in_end
    |=> mode_bits == $past(shift_in[MODE_HI:MODE_LO])) // R25
    else $error("mode register write lost");
endmodule

// ---- dv/spi_host_model.sv ----
`timescale 1ns/1ps
module spi_host_model (
  output logic select_n,
  output logic sck,
  output logic [3:0] pin,
  input wire logic [3:0] dev_out,
  input wire logic [3:0] dev_oe_n
);
  logic [3:0] drv_val;
  logic [3:0] drv_en;
  int width;

  initial
  begin
    select_n = 1'b1;
    sck = 1'b0;
    drv_val = 4'hF;
    drv_en = 4'h9;
    width = 1;
  end

  // A released lane shows the inverse of its last driven value
  always_comb
    for (int i = 0; i < 4; i++)
      pin[i] = !dev_oe_n[i] ? dev_out[i] : drv_val[i] ^ !drv_en[i];

  function automatic logic [3:0] en_of(input bit rd);
    if (width == 1)
      return 4'h9;
    if (width == 2)
      return rd ? 4'h8 : 4'hB;
    return rd ? 4'h0 : 4'hF;
  endfunction

  task automatic start();
    if (width < 4)
      drv_val[3] = 1'b1;
    drv_en = en_of(1'b0);
    select_n = 1'b0;
    #100;
  endtask

  task automatic stop();
    #100;
    select_n = 1'b1;
    #250;
  endtask

  task automatic shift(input logic [7:0] tx, input bit rd,
                       output logic [7:0] rx);
    rx = 8'h00;
    drv_en = en_of(rd);
    for (int b = 8 - width; b >= 0; b -= width)
    begin
      for (int k = 0; k < width; k++)
        if (!rd)
          drv_val[k] = tx[b + k];
      #62.5;
      for (int k = 0; k < width; k++)
        rx[b + k] = pin[(width == 1) ? 1 : k];
      sck = 1'b1;
      #62.5;
      sck = 1'b0;
    end
  endtask

  task automatic hold(input bit on);
    // Pause moves half a clock after the falling edge, never with it
    #62.5;
    drv_val[3] = !on;
    #100;
  endtask

  task automatic wiggle();
    repeat (3)
    begin
      drv_val[0] = ~drv_val[0];
      #62.5 sck = 1'b1;
      #62.5 sck = 1'b0;
    end
  endtask
endmodule

// ---- dv/serial_sram_multi_io_access_tb.sv ----
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
module serial_sram_multi_io_access_tb
  import sram_pkg::*;
;
  logic clk;
  logic rst_n;
  logic select_n;
  logic sck;
  logic [3:0] pin;
  logic [3:0] dout;
  logic [3:0] doe_n;
  logic [1:0] mode_bits;
  logic dual_io_mode;
  logic quad_io_mode;
  logic paused;
  int compares = 0;
  int miscompares = 0;
  logic [31:0] seed = 32'h00000006;
  logic [7:0] mem [int];
  logic [1:0] mode_m;

  serial_sram DUT (
    .clk(clk), .rst_n(rst_n), .select_n(select_n), .sck(sck),
    .io_lane_0_in(pin[0]), .io_lane_0_out(dout[0]),
    .io_lane_0_oe_n(doe_n[0]), .io_lane_1_in(pin[1]),
    .io_lane_1_out(dout[1]), .io_lane_1_oe_n(doe_n[1]),
    .io_lane_2_in(pin[2]), .io_lane_2_out(dout[2]),
    .io_lane_2_oe_n(doe_n[2]), .io_lane_3_in(pin[3]),
    .io_lane_3_out(dout[3]), .io_lane_3_oe_n(doe_n[3]),
    .mode_bits(mode_bits), .dual_io_mode(dual_io_mode),
    .quad_io_mode(quad_io_mode), .paused(paused)
  );

  spi_host_model M (
    .select_n(select_n), .sck(sck), .pin(pin),
    .dev_out(dout), .dev_oe_n(doe_n)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  function automatic logic [17:0] nxt(input logic [17:0] a);
    if (mode_m == MODE_BYTE)
      return a;
    if (mode_m == MODE_PAGE)
      return {a[17:5], a[4:0] + 5'h01};
    return a + 18'h00001;
  endfunction

  task automatic finish_test();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic op_only(input logic [7:0] op);
    logic [7:0] r;
    M.start();
    M.shift(op, 1'b0, r);
    M.stop();
  endtask

  task automatic set_mode(input logic [1:0] m);
    logic [7:0] r;
    M.start();
    M.shift(OP_WRITE_MODE, 1'b0, r);
    M.shift({m, 6'h00}, 1'b0, r);
    M.stop();
    mode_m = m;
    M.start();
    M.shift(OP_READ_MODE, 1'b0, r);
    M.shift(8'h00, 1'b1, r);
    M.shift(8'h00, 1'b1, r);
    M.stop();
    `CHK(r, {m, 6'h00});
    `CHK(mode_bits, m);
  endtask

  task automatic access(input logic [7:0] op, input logic [17:0] adr,
                        input int n, input bit rd, input bit hold);
    logic [7:0] d;
    logic [7:0] r;
    logic [17:0] a;
    a = adr;
    d = rnd();
    M.start();
    M.shift(op, 1'b0, r);
    M.shift({d[5:0], adr[17:16]}, 1'b0, r);
    M.shift(adr[15:8], 1'b0, r);
    M.shift(adr[7:0], 1'b0, r);
    for (int i = 0; i < n; i++)
    begin
      d = rnd();
      M.shift(d, rd, r);
      if (rd && (mode_m != MODE_BYTE || i == 0))
        `CHK(r, mem[a]);
      if (!rd && (mode_m != MODE_BYTE || i == 0))
        mem[a] = d;
      a = nxt(a);
      if (hold && i == 0)
      begin
        M.hold(1'b1);
        `CHK({paused, doe_n[1]}, 2'b11);
        M.wiggle();
        M.hold(1'b0);
        `CHK({paused, doe_n[1]}, 2'b00);
      end
    end
    if (rd && mode_m == MODE_BYTE)
      `CHK(doe_n[1], 1'b1);
    M.stop();
    `CHK(doe_n, 4'hF);
  endtask

  initial
  begin
    #600000;
    miscompares++;
    finish_test();
  end

  initial
  begin
    logic [23:0] a;
    logic [7:0] r;
    rst_n = 1'b0;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (5) @(posedge clk);
    `CHK(mode_bits, MODE_RESET);
    `CHK(doe_n, 4'hF);
    set_mode(MODE_SEQ);
    access(OP_WRITE, 18'h3FFFF, 3, 1'b0, 1'b0);
    access(OP_READ, 18'h3FFFF, 3, 1'b1, 1'b1);
    set_mode(MODE_PAGE);
    a = {rnd(), rnd(), 3'h0, 5'h1E};
    access(OP_WRITE, a[17:0], 3, 1'b0, 1'b0);
    access(OP_READ, a[17:0], 3, 1'b1, 1'b0);
    set_mode(MODE_SEQ);
    access(OP_WRITE, 18'h01234, 2, 1'b0, 1'b0);
    set_mode(MODE_BYTE);
    access(OP_WRITE, 18'h01234, 2, 1'b0, 1'b0);
    access(OP_READ, 18'h01234, 2, 1'b1, 1'b0);
    set_mode(2'h3);
    access(OP_READ, 18'h01234, 2, 1'b1, 1'b0);
    for (int j = 0; j < 2; j++)
    begin
      op_only(j == 0 ? OP_ENTER_DUAL : OP_ENTER_QUAD);
      M.width = (j == 0) ? 2 : 4;
      `CHK({dual_io_mode, quad_io_mode}, j == 0 ? 2'b10 : 2'b01);
      a = {rnd(), rnd(), rnd()};
      access(OP_WRITE, a[17:0], 4, 1'b0, 1'b0);
      access(OP_READ, a[17:0], 4, 1'b1, 1'b0);
      op_only(OP_EXIT_MULTI);
      M.width = 1;
      `CHK({dual_io_mode, quad_io_mode}, 2'b00);
    end
    M.start();
    M.shift(8'hA5, 1'b0, r);
    repeat (3) M.shift(8'h00, 1'b1, r);
    `CHK(doe_n, 4'hF);
    M.stop();
    finish_test();
  end
endmodule
